/* hdl/ipa_edge_det.sv */
// One source front end: level or edge capture into a pending flag
module ipa_edge_det
   import ipa_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic src_i,
   input  wire logic edge_mode_i,
   input  wire logic sw_set_i,
   input  wire logic sw_clr_i,
   input  wire logic ack_clr_i,
   output logic      pend_o
);
   logic src_q;
   logic pend_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src_i;
      end
   end

   // Set wins over any clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
      end else if (sw_set_i || (edge_mode_i && src_i && !src_q)) begin
         pend_q <= 1'b1;
      end else if (!edge_mode_i) begin
         pend_q <= src_i && !sw_clr_i;
      end else if (sw_clr_i || ack_clr_i) begin
         pend_q <= 1'b0;
      end
   end

   assign pend_o = pend_q;
endmodule

/* hdl/ipa_pkg.sv */
// Package for the interrupt prioritizer: register map, field layout and types
package ipa_pkg;
   localparam int unsigned IPA_NSRC = 6;
   localparam int unsigned IPA_AW   = 4;
   localparam int unsigned IPA_VW   = 8;

   // Register byte offsets on the Wishbone slave
   localparam logic [IPA_AW-1:0] IPA_OFF_CTRL   = 4'h0;
   localparam logic [IPA_AW-1:0] IPA_OFF_MASK   = 4'h4;
   localparam logic [IPA_AW-1:0] IPA_OFF_CAUSE  = 4'h8;
   localparam logic [IPA_AW-1:0] IPA_OFF_SRC    = 4'hc;

   // Control register fields
   localparam int unsigned IPA_CTRL_GATE    = 0;
   localparam int unsigned IPA_CTRL_AUXEN   = 1;
   localparam int unsigned IPA_CTRL_IRQ_LSB = 8;
   localparam int unsigned IPA_CTRL_TRG_LSB = 16;
   localparam int unsigned IPA_CTRL_PRI_LSB = 24;

   // Auxiliary mask and cause bit positions
   localparam int unsigned IPA_BIT_CONV = 5;
   localparam int unsigned IPA_BIT_SUM  = 6;

   // Source register fields: pending flags and status
   localparam int unsigned IPA_SRC_PEND_LSB = 0;
   localparam int unsigned IPA_SRC_ACT_LSB  = 8;
   localparam int unsigned IPA_SRC_VLD      = 16;
   localparam int unsigned IPA_SRC_ID_LSB   = 20;

   localparam logic [7:0] IPA_MASK_RST  = 8'h00;
   localparam logic [7:0] IPA_CTRL8_RST = 8'h00;
   localparam logic [3:0] IPA_ACC_RST   = 4'h8;
   localparam logic [2:0] IPA_AUX_ID    = 3'h6;

   typedef struct packed {
      logic       req;
      logic [2:0] id;
      logic [7:0] vector;
   } ipa_grant_s;

   typedef enum logic [1:0] {
      IPA_IDLE = 2'b00,
      IPA_ISSUE = 2'b01,
      IPA_WAIT = 2'b11
   } ipa_state_e;
endpackage

/* hdl/ipa_top.sv */
// Interrupt prioritizer with auxiliary merged interrupt, Wishbone registers
//
// Decided for this implementation: the address map and the Wishbone register port.
module ipa_top
   import ipa_pkg::*;
#(
   parameter int unsigned NSRC = IPA_NSRC,
   parameter logic [IPA_VW*IPA_NSRC-1:0] VECTORS = 48'h2b_23_1b_13_0b_03,
   parameter logic [IPA_VW-1:0] AUX_VECTOR = 8'h33
)
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [IPA_AW-1:0]    adr_i,
   input  wire logic [31:0]          dat_i,
   input  wire logic                 we_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   input  wire logic [NSRC-1:0]      src_i,
   input  wire logic                 conv_done_i,
   input  wire logic                 result_done_i,
   input  wire logic                 int_ack_i,
   input  wire logic                 reti_i,
   output logic                      irq_req_o,
   output logic      [IPA_VW-1:0]    irq_vector_o,
   output logic      [2:0]           irq_id_o
);
   logic [7:0]      gate_en_q;
   logic [NSRC-1:0] en_q;
   logic [NSRC-1:0] trig_q;
   logic [NSRC-1:0] pri_q;
   logic [7:0]      aux_mask_q;
   logic [7:0]      cause_q;
   logic [3:0]      acc_count_q;
   logic [3:0]      acc_cnt_q;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] sw_set;
   logic [NSRC-1:0] sw_clr;
   logic [NSRC-1:0] ack_clr;
   logic [NSRC-1:0] act_lo_q;
   logic [NSRC-1:0] act_hi_q;
   logic            aux_act_q;
   logic            sum_pulse;
   logic            aux_merged_interrupt;
   logic            global_irq_gate;
   logic            aux_irq_enable_bit;
   logic            wr;
   logic            rd_ack;
   ipa_grant_s      pick;
   ipa_grant_s      grant_q;
   ipa_state_e      state_q;
   logic [31:0]     rdata;

   // Writes land on the edge at which the master samples ack high
   assign wr = cyc_i && stb_i && we_i && ack_o;
   assign global_irq_gate    = gate_en_q[IPA_CTRL_GATE];
   assign aux_irq_enable_bit = gate_en_q[IPA_CTRL_AUXEN];

   // Wishbone slave: one wait state, ack lasts one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end
   assign rd_ack = cyc_i && stb_i && !we_i && !ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_en_q <= IPA_CTRL8_RST;
         en_q      <= '0;
         trig_q    <= '0;
         pri_q     <= '0;
      end else if (wr && adr_i == IPA_OFF_CTRL) begin
         if (sel_i[0]) gate_en_q <= dat_i[7:0];
         if (sel_i[1]) en_q   <= dat_i[IPA_CTRL_IRQ_LSB +: NSRC];
         if (sel_i[2]) trig_q <= dat_i[IPA_CTRL_TRG_LSB +: NSRC];
         if (sel_i[3]) pri_q  <= dat_i[IPA_CTRL_PRI_LSB +: NSRC];
      end
   end

   // Auxiliary enable mask; bits 3:0 of byte 1 set the accumulation count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aux_mask_q  <= IPA_MASK_RST;
         acc_count_q <= IPA_ACC_RST;
      end else if (wr && adr_i == IPA_OFF_MASK) begin
         if (sel_i[0]) aux_mask_q  <= dat_i[7:0];
         if (sel_i[1]) acc_count_q <= dat_i[11:8];
      end
   end

   // Counts conversion results and pulses when the set count is reached
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_cnt_q <= '0;
      end else if (result_done_i) begin
         if (acc_cnt_q + 4'h1 >= acc_count_q) begin
            acc_cnt_q <= '0;
         end else begin
            acc_cnt_q <= acc_cnt_q + 4'h1;
         end
      end
   end
   assign sum_pulse = result_done_i && (acc_cnt_q + 4'h1 >= acc_count_q);

   // Cause flags: write one to clear, a new event wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_q <= '0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if ((i == IPA_BIT_CONV && conv_done_i) || (i == IPA_BIT_SUM && sum_pulse)) begin
               cause_q[i] <= 1'b1;
            end else if (wr && adr_i == IPA_OFF_CAUSE && sel_i[0] && dat_i[i]) begin
               cause_q[i] <= 1'b0;
            end
         end
      end
   end

   // Merged auxiliary request, independent of the global gate
   assign aux_merged_interrupt = aux_irq_enable_bit &&
                                 |(cause_q & aux_mask_q);

   always_comb begin
      sw_set = '0;
      sw_clr = '0;
      if (wr && adr_i == IPA_OFF_SRC && sel_i[0]) begin
         sw_set = dat_i[IPA_SRC_PEND_LSB +: NSRC];
         sw_clr = ~dat_i[IPA_SRC_PEND_LSB +: NSRC];
      end
   end

   always_comb begin
      ack_clr = '0;
      if (state_q == IPA_ISSUE && int_ack_i && grant_q.id != IPA_AUX_ID) begin
         ack_clr[grant_q.id] = 1'b1;
      end
   end

   for (genvar g = 0; g < NSRC; g++) begin : g_src
      ipa_edge_det u_det (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .src_i       (src_i[g]),
         .edge_mode_i (trig_q[g]),
         .sw_set_i    (sw_set[g]),
         .sw_clr_i    (sw_clr[g]),
         .ack_clr_i   (ack_clr[g]),
         .pend_o      (pend[g])
      );
   end

   // Selection: auxiliary first, then high level, then low, lowest index wins
   always_comb begin
      pick = '0;
      if (aux_merged_interrupt && !aux_act_q) begin
         pick.req    = 1'b1;
         pick.id     = IPA_AUX_ID;
         pick.vector = AUX_VECTOR;
      end else if (global_irq_gate && !aux_act_q) begin
         for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i] && en_q[i] && pri_q[i] && act_hi_q == '0) begin
               pick.req    = 1'b1;
               pick.id     = 3'(i);
               pick.vector = VECTORS[i*IPA_VW +: IPA_VW];
            end
         end
         if (!pick.req && act_hi_q == '0 && act_lo_q == '0) begin
            for (int i = NSRC - 1; i >= 0; i--) begin
               if (pend[i] && en_q[i] && !pri_q[i]) begin
                  pick.req    = 1'b1;
                  pick.id     = 3'(i);
                  pick.vector = VECTORS[i*IPA_VW +: IPA_VW];
               end
            end
         end
      end
   end

   // Request is held to the core until it acknowledges, or dropped when nothing is picked any more
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= IPA_IDLE;
         grant_q <= '0;
      end else begin
         unique case (state_q)
            IPA_IDLE: begin
               if (pick.req) begin
                  state_q <= IPA_ISSUE;
                  grant_q <= pick;
               end
            end
            IPA_ISSUE: begin
               if (int_ack_i) begin
                  state_q <= IPA_WAIT;
                  grant_q.req <= 1'b0;
               end else if (!pick.req) begin
                  state_q <= IPA_IDLE;
                  grant_q.req <= 1'b0;
               end else begin
                  grant_q <= pick;
               end
            end
            IPA_WAIT: begin
               state_q <= IPA_IDLE;
            end
         endcase
      end
   end

   // In-service tracking, most recent level is ended by return
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_lo_q  <= '0;
         act_hi_q  <= '0;
         aux_act_q <= 1'b0;
      end else if (state_q == IPA_ISSUE && int_ack_i) begin
         if (grant_q.id == IPA_AUX_ID) begin
            aux_act_q <= 1'b1;
         end else if (pri_q[grant_q.id]) begin
            act_hi_q[grant_q.id] <= 1'b1;
         end else begin
            act_lo_q[grant_q.id] <= 1'b1;
         end
      end else if (reti_i) begin
         if (aux_act_q) begin
            aux_act_q <= 1'b0;
         end else if (act_hi_q != '0) begin
            act_hi_q <= '0;
         end else begin
            act_lo_q <= '0;
         end
      end
   end

   always_comb begin
      rdata = '0;
      unique case (adr_i)
         IPA_OFF_CTRL: begin
            rdata[7:0] = gate_en_q;
            rdata[IPA_CTRL_IRQ_LSB +: NSRC] = en_q;
            rdata[IPA_CTRL_TRG_LSB +: NSRC] = trig_q;
            rdata[IPA_CTRL_PRI_LSB +: NSRC] = pri_q;
         end
         IPA_OFF_MASK: rdata[11:0] = {acc_count_q, aux_mask_q};
         IPA_OFF_CAUSE: rdata[7:0] = cause_q;
         IPA_OFF_SRC: begin
            rdata[IPA_SRC_PEND_LSB +: NSRC] = pend;
            rdata[IPA_SRC_ACT_LSB +: NSRC]  = act_lo_q | act_hi_q;
            rdata[IPA_SRC_VLD]              = aux_act_q;
            rdata[IPA_SRC_ID_LSB +: 3]      = grant_q.id;
         end
         default: rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (rd_ack) begin
         dat_o <= rdata;
      end
   end

   assign irq_req_o    = grant_q.req;
   assign irq_vector_o = grant_q.vector;
   assign irq_id_o     = grant_q.id;
endmodule

/* sim/ipa_core_model.sv */
// Processor core model: takes vectors and returns from service after a while
module ipa_core_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic en_i,
   input  wire logic irq_req_i,
   output logic      int_ack_o,
   output logic      reti_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] svc_q;
   // Acks only when idle and allowed; the service routine lasts five cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_ack_o <= 1'b0;
         reti_o    <= 1'b0;
         svc_q     <= 3'h0;
      end else begin
         int_ack_o <= en_i && irq_req_i && !int_ack_o && svc_q == 3'h0;
         reti_o    <= svc_q == 3'h1;
         if (int_ack_o) svc_q <= 3'h5;
         else if (svc_q != 3'h0) svc_q <= svc_q - 3'h1;
      end
   end
endmodule

/* sim/ipa_monitor.sv */
// Checker of bus handshake and interrupt request rules at the prioritizer ports
module ipa_monitor
   import ipa_pkg::*;
#(
   parameter int unsigned                NSRC       = IPA_NSRC,
   parameter logic [IPA_VW*IPA_NSRC-1:0] VECTORS    = '0,
   parameter logic [IPA_VW-1:0]          AUX_VECTOR = '0
)
(
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic [IPA_AW-1:0] adr_i,
   input wire logic [31:0]       dat_i,
   input wire logic              we_i,
   input wire logic [3:0]        sel_i,
   input wire logic              cyc_i,
   input wire logic              stb_i,
   input wire logic [31:0]       dat_o,
   input wire logic              ack_o,
   input wire logic [NSRC-1:0]   src_i,
   input wire logic              conv_done_i,
   input wire logic              result_done_i,
   input wire logic              int_ack_i,
   input wire logic              reti_i,
   input wire logic              irq_req_o,
   input wire logic [IPA_VW-1:0] irq_vector_o,
   input wire logic [2:0]        irq_id_o
);
   logic gate_q;
   logic aux_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence bus_req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence taken_s;
      irq_req_o && int_ack_i;
   endsequence
   // Shadow of the two enable bits, updated where the slave takes the write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_q <= 1'b0;
         aux_q  <= 1'b0;
      end else if (cyc_i && stb_i && ack_o && we_i && adr_i == IPA_OFF_CTRL && sel_i[0]) begin
         gate_q <= dat_i[IPA_CTRL_GATE];
         aux_q  <= dat_i[IPA_CTRL_AUXEN];
      end
   end
   bus_answer_a: assert property (bus_req_s |=> ack_o)
      else $error("bus request not answered");
   ack_once_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   irq_drop_a: assert property (taken_s |=> !irq_req_o)
      else $error("request kept after acknowledge");
   aux_vector_a: assert property (irq_req_o && irq_id_o == IPA_AUX_ID |-> irq_vector_o == AUX_VECTOR)
      else $error("wrong auxiliary vector");
   src_vector_a: assert property (irq_req_o && irq_id_o != IPA_AUX_ID
      |-> irq_vector_o == VECTORS[irq_id_o*IPA_VW +: IPA_VW])
      else $error("wrong source vector");
   gate_block_a: assert property (!gate_q [*3] |-> !(irq_req_o && irq_id_o != IPA_AUX_ID))
      else $error("ordinary request with gate off");
   aux_block_a: assert property (!aux_q [*3] |-> !(irq_req_o && irq_id_o == IPA_AUX_ID))
      else $error("auxiliary request while disabled");
   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !irq_req_o && !ack_o)
      else $error("outputs active after reset");
endmodule

/* sim/ipa_top_bench.sv */
// Self-checking bench for the interrupt prioritizer
module ipa_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import ipa_pkg::*;
   localparam logic [47:0] VEC = 48'h2b_23_1b_13_0b_03;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  adr   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic [31:0] rd;
   logic        we    = 1'b0;
   logic        cyc   = 1'b0;
   logic        en    = 1'b0;
   logic [5:0]  src   = 6'h0;
   logic [1:0]  ev    = 2'h0;
   logic [31:0] dat_o;
   logic        ack_o, int_ack, reti, irq_req_o;
   logic [7:0]  irq_vector_o;
   logic [2:0]  irq_id_o;
   int          num_errors = 0;
   int          cmp_count  = 0;
   always #5 clk_i = ~clk_i;
   ipa_top #(.VECTORS(VEC), .AUX_VECTOR(8'h33)) dut_u (.clk_i, .rst_i, .adr_i(adr),
      .dat_i(wdat), .we_i(we), .sel_i(4'hf), .cyc_i(cyc), .stb_i(cyc), .dat_o, .ack_o,
      .src_i(src), .conv_done_i(ev[0]), .result_done_i(ev[1]), .int_ack_i(int_ack),
      .reti_i(reti), .irq_req_o, .irq_vector_o, .irq_id_o);
   ipa_core_model core_u (.clk_i, .rst_i, .en_i(en), .irq_req_i(irq_req_o),
      .int_ack_o(int_ack), .reti_o(reti));
   task automatic stop_test;
      if (num_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a; we <= w; wdat <= d; cyc <= 1'b1;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 40);
      rd = dat_o;
      cyc <= 1'b0;
      if (n >= 40) num_errors++;
   endtask
   task automatic quiet(input int n);
      repeat (2) @(posedge clk_i);
      repeat (n) begin @(posedge clk_i); check(irq_req_o, 32'h0); end
   endtask
   task automatic grant(input logic [2:0] id);
      int n;
      n = 0;
      while (irq_req_o !== 1'b1 && n < 60) begin @(posedge clk_i); n++; end
      check(irq_req_o, 32'h1);
      check(irq_id_o, id);
      check(irq_vector_o, id == IPA_AUX_ID ? 8'h33 : VEC[id*8 +: 8]);
   endtask
   task automatic pulse(input logic [1:0] m);
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= 2'h0;
   endtask
   task automatic t_reset;
      logic [3:0]  a [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
      logic [31:0] e [5] = '{32'h0, 32'h800, 32'h0, 32'h0, 32'h0};
      wb(4'h2, 1'b1, 32'hffffffff);
      foreach (a[i]) begin wb(a[i], 1'b0, 32'h0); check(rd, e[i]); end
   endtask
   task automatic t_gate;
      wb(IPA_OFF_CTRL, 1'b1, 32'h400);
      src <= 6'h04;
      quiet(8);
      wb(IPA_OFF_SRC, 1'b0, 32'h0);
      check(rd & 32'h3f, 32'h04);
      en <= 1'b1;
      wb(IPA_OFF_CTRL, 1'b1, 32'h401);
      grant(3'h2);
      src <= 6'h00;
      repeat (3) @(posedge clk_i);
      quiet(10);
   endtask
   task automatic t_tie;
      en <= 1'b0;
      wb(IPA_OFF_CTRL, 1'b1, 32'h000a_0a01);
      wb(IPA_OFF_SRC, 1'b1, 32'h0a);
      grant(3'h1);
      en <= 1'b1;
      repeat (3) @(posedge clk_i);
      en <= 1'b0;
      wb(IPA_OFF_SRC, 1'b0, 32'h0);
      check(rd & 32'h3f, 32'h08);
      en <= 1'b1;
      grant(3'h3);
      repeat (12) @(posedge clk_i);
   endtask
   task automatic t_aux;
      en <= 1'b0;
      wb(IPA_OFF_CTRL, 1'b1, 32'h2);
      wb(IPA_OFF_MASK, 1'b1, 32'h340);
      pulse(2'h1);
      quiet(6);
      pulse(2'h2);
      pulse(2'h2);
      quiet(6);
      pulse(2'h2);
      grant(IPA_AUX_ID);
      wb(IPA_OFF_CAUSE, 1'b0, 32'h0);
      check(rd & 32'h40, 32'h40);
      wb(IPA_OFF_CAUSE, 1'b1, 32'h60);
      quiet(6);
      wb(IPA_OFF_CTRL, 1'b1, 32'h103);
      src <= 6'h01;
      wb(IPA_OFF_MASK, 1'b1, 32'h360);
      pulse(2'h1);
      repeat (3) @(posedge clk_i);
      grant(IPA_AUX_ID);
      wb(IPA_OFF_CAUSE, 1'b1, 32'h60);
      repeat (3) @(posedge clk_i);
      grant(3'h0);
      src <= 6'h00;
      wb(IPA_OFF_CTRL, 1'b1, 32'h0);
      pulse(2'h1);
      quiet(6);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_gate;
      t_tie;
      t_aux;
      stop_test;
   end
   initial begin
      #100000;
      num_errors++;
      stop_test;
   end
endmodule
bind ipa_top ipa_monitor #(.NSRC(NSRC), .VECTORS(VECTORS), .AUX_VECTOR(AUX_VECTOR)) mon_u (
   .clk_i, .rst_i, .adr_i, .dat_i, .we_i, .sel_i, .cyc_i, .stb_i, .dat_o, .ack_o, .src_i,
   .conv_done_i, .result_done_i, .int_ack_i, .reti_i, .irq_req_o, .irq_vector_o, .irq_id_o);
